/* hw/hibernation_power_control.v */
// hibernation power controller: regulator enable, wake logic, counter,
// match compare, status and retained data words
// assumes a single mclk domain and the slow oscillator sampled as a plain input
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "hib_map.vh"

// What this block does
// [R01] drive regulator enable output that switches main power off in hibernation
// [R02] in hibernation restore power on wake pin or counter match
// [R03] detect low battery and optionally refuse hibernation
// [R04] host spaces writes, and write-then-read, to the slow registers
// [R05] back-to-back reads are accepted with no spacing
// [R06] host always supplies an oscillator clock to the block
// [R07] crystal source is divided by 128 to form the reference
// [R08] clock source counts only while oscillator enable is set
// [R09] select 0 takes crystal divide path, 1 takes oscillator directly
// [R10] after enabling a crystal host waits settling before other access
// [R11] with an oscillator host may access registers at once
// [R12] 32-bit counter and two 32-bit match values for wake or event
// [R13] sixty-four 32-bit words retained across hibernation
// [R14] match, wake and low battery events individually maskable
// [R15] hibernation starts on request bit after a wake source is configured
// [R16] timer wake and pin wake each gated by their own enable
// [R17] low battery with detect and abort set prevents hibernation entry
// [R18] counter ticks per second, trim divisor used one second in 64
// [R19] regulator enable is active low; writes land safely in the counter domain
module hibernation_power_control #(
    parameter DATA_WORDS = 64
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // register port
    input  wire [8:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rd_data_q,
    // pins
    input  wire        osc_in,
    input  wire        wake_n,
    input  wire        low_batt,
    output reg         regulator_power_enable_n_q,
    output reg         event_pending_q
);

    localparam ST_RUN = 1'b0;
    localparam ST_HIB = 1'b1;

    reg                         state_q;
    reg  [`HIB_CTRL_W-1:0]      ctrl_q;
    reg  [31:0]                 count_q;
    reg  [31:0]                 match0_q;
    reg  [31:0]                 match1_q;
    reg  [15:0]                 trim_q;
    reg  [`HIB_ST_W-1:0]        mask_q;
    reg  [`HIB_ST_W-1:0]        raw_q;
    reg  [31:0]                 data_mem [0:DATA_WORDS-1];
    wire                        second_tick;
    wire [31:0]                 count_next;
    wire                        hit0;
    wire                        hit1;
    wire                        pin_wake;
    wire                        tmr_wake;
    wire                        wake_cond;
    wire                        wake_cfg;
    wire                        abort_cond;
    wire                        enter_hib;
    wire                        refuse_hib;
    wire [`HIB_ST_W-1:0]        set_bits;
    wire [`HIB_ST_W-1:0]        clr_bits;
    wire [`HIB_ST_W-1:0]        raw_next;

    // register decode, shared by the read and write paths
    function is_reg;
        input [8:0] a;
        input [8:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    function is_data;
        input [8:0] a;
        begin
            is_data = (a >= `HIB_OFS_DATA_BASE) && (a[1:0] == 2'b00);
        end
    endfunction

    osc_predivider u_prediv (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .osc_in          (osc_in),
        .osc_enable      (ctrl_q[`HIB_CTRL_OSC_EN]),
        .osc_type_select (ctrl_q[`HIB_CTRL_OSC_SEL]),
        .count_enable    (ctrl_q[`HIB_CTRL_COUNT_EN]),
        .trim            (trim_q),
        .second_tick_q   (second_tick)
    );

    // counter and match compare
    assign count_next = count_q + 32'h00000001;
    assign hit0 = second_tick && (count_next == match0_q); // see [R12]
    assign hit1 = second_tick && (count_next == match1_q); // see [R12]

    // wake sources, each behind its own enable
    assign pin_wake  = ctrl_q[`HIB_CTRL_PIN_WAKE] & ~wake_n; // see [R16]
    assign tmr_wake  = ctrl_q[`HIB_CTRL_TMR_WAKE] & (hit0 | hit1); // see [R16]
    assign wake_cond = pin_wake | tmr_wake; // see [R02]
    assign wake_cfg  = ctrl_q[`HIB_CTRL_PIN_WAKE] | ctrl_q[`HIB_CTRL_TMR_WAKE]; // see [R15]

    // battery checked only while running
    assign abort_cond = ctrl_q[`HIB_CTRL_LOWB_EN] & ctrl_q[`HIB_CTRL_ABORT] & low_batt; // see [R17]
    assign enter_hib  = (state_q == ST_RUN) && ctrl_q[`HIB_CTRL_HIB_REQ]
                        && wake_cfg && !abort_cond; // see [R15] see [R03]
    assign refuse_hib = (state_q == ST_RUN) && ctrl_q[`HIB_CTRL_HIB_REQ] && !enter_hib;

    // sticky status, set wins over clear
    assign set_bits[`HIB_ST_LOWBAT] = ctrl_q[`HIB_CTRL_LOWB_EN] & low_batt
                                      & (state_q == ST_RUN); // see [R03]
    assign set_bits[`HIB_ST_MATCH0] = hit0;
    assign set_bits[`HIB_ST_MATCH1] = hit1;
    assign set_bits[`HIB_ST_WAKE]   = ~wake_n;
    assign clr_bits = (wr_en && is_reg(addr, `HIB_OFS_CLEAR)) ? wr_data[`HIB_ST_W-1:0]
                                                             : {`HIB_ST_W{1'b0}};
    assign raw_next = (raw_q & ~clr_bits) | set_bits; // see [R14]

    // power state machine
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q                    <= ST_RUN;
            regulator_power_enable_n_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (enter_hib) begin
                        state_q                    <= ST_HIB;
                        regulator_power_enable_n_q <= 1'b1; // see [R01] see [R19]
                    end
                end
                ST_HIB: begin
                    if (wake_cond) begin
                        state_q                    <= ST_RUN;
                        regulator_power_enable_n_q <= 1'b0; // see [R02]
                    end
                end
                default: begin
                    state_q                    <= ST_RUN;
                    regulator_power_enable_n_q <= 1'b0;
                end
            endcase
        end
    end

    // control word; request bit cleared by hardware on refusal or wake
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `HIB_CTRL_RST;
        end else begin
            if (wr_en && is_reg(addr, `HIB_OFS_CTRL))
                ctrl_q <= wr_data[`HIB_CTRL_W-1:0]; // see [R19]
            else if (refuse_hib || (state_q == ST_HIB && wake_cond))
                ctrl_q[`HIB_CTRL_HIB_REQ] <= 1'b0; // see [R03]
        end
    end

    // counter, match, trim, mask and status
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_q  <= 32'h00000000;
            match0_q <= `HIB_MATCH_RST;
            match1_q <= `HIB_MATCH_RST;
            trim_q   <= `HIB_TRIM_RST;
            mask_q   <= {`HIB_ST_W{1'b0}};
            raw_q    <= {`HIB_ST_W{1'b0}};
        end else begin
            raw_q <= raw_next;
            if (wr_en && is_reg(addr, `HIB_OFS_LOAD))
                count_q <= wr_data; // see [R19]
            else if (second_tick)
                count_q <= count_next; // see [R18]
            if (wr_en && is_reg(addr, `HIB_OFS_MATCH0))
                match0_q <= wr_data;
            if (wr_en && is_reg(addr, `HIB_OFS_MATCH1))
                match1_q <= wr_data;
            if (wr_en && is_reg(addr, `HIB_OFS_TRIM))
                trim_q <= wr_data[15:0]; // see [R18]
            if (wr_en && is_reg(addr, `HIB_OFS_MASK))
                mask_q <= wr_data[`HIB_ST_W-1:0]; // see [R14]
        end
    end

    // masked events onto one output
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            event_pending_q <= 1'b0;
        else
            event_pending_q <= |(raw_next & mask_q); // see [R14]
    end

    // retained data words
    always @(posedge mclk) begin
        if (wr_en && is_data(addr))
            data_mem[addr[7:2]] <= wr_data; // see [R13]
    end

    // read data one cycle after the strobe; reads need no spacing
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 32'h00000000;
        end else if (rd_en) begin // see [R05]
            if (is_data(addr))
                rd_data_q <= data_mem[addr[7:2]]; // see [R13]
            else if (is_reg(addr, `HIB_OFS_COUNT))
                rd_data_q <= count_q;
            else if (is_reg(addr, `HIB_OFS_MATCH0))
                rd_data_q <= match0_q;
            else if (is_reg(addr, `HIB_OFS_MATCH1))
                rd_data_q <= match1_q;
            else if (is_reg(addr, `HIB_OFS_CTRL))
                rd_data_q <= {24'h000000, ctrl_q};
            else if (is_reg(addr, `HIB_OFS_MASK))
                rd_data_q <= {28'h0000000, mask_q};
            else if (is_reg(addr, `HIB_OFS_RAW))
                rd_data_q <= {28'h0000000, raw_q};
            else if (is_reg(addr, `HIB_OFS_MASKED))
                rd_data_q <= {28'h0000000, raw_q & mask_q};
            else if (is_reg(addr, `HIB_OFS_TRIM))
                rd_data_q <= {16'h0000, trim_q};
            else
                rd_data_q <= 32'h00000000;
        end else begin
            rd_data_q <= 32'h00000000;
        end
    end

endmodule

/* hw/hib_map.vh */
// register offsets, control field positions, reset values and counts
// for the hibernation power controller; definitions only
`ifndef HIB_MAP_VH
`define HIB_MAP_VH

// register byte offsets
`define HIB_OFS_COUNT      9'h000
`define HIB_OFS_MATCH0     9'h004
`define HIB_OFS_MATCH1     9'h008
`define HIB_OFS_LOAD       9'h00c
`define HIB_OFS_CTRL       9'h010
`define HIB_OFS_MASK       9'h014
`define HIB_OFS_RAW        9'h018
`define HIB_OFS_MASKED     9'h01c
`define HIB_OFS_CLEAR      9'h020
`define HIB_OFS_TRIM       9'h024
`define HIB_OFS_DATA_BASE  9'h100

// control word fields
`define HIB_CTRL_COUNT_EN  0
`define HIB_CTRL_HIB_REQ   1
`define HIB_CTRL_OSC_SEL   2
`define HIB_CTRL_TMR_WAKE  3
`define HIB_CTRL_PIN_WAKE  4
`define HIB_CTRL_LOWB_EN   5
`define HIB_CTRL_OSC_EN    6
`define HIB_CTRL_ABORT     7
`define HIB_CTRL_W         8

// status fields
`define HIB_ST_LOWBAT      0
`define HIB_ST_MATCH0      1
`define HIB_ST_MATCH1      2
`define HIB_ST_WAKE        3
`define HIB_ST_W           4

// reset values
`define HIB_CTRL_RST       8'h00
`define HIB_TRIM_RST       16'h7fff
`define HIB_MATCH_RST      32'hffffffff

// clock division counts
`define HIB_XTAL_DIV       128
`define HIB_PREDIV_NOM     16'h7fff
`define HIB_TRIM_PERIOD    64

`endif

/* hw/osc_predivider.v */
// slow oscillator sampling, crystal divide and one-second predivider
// assumes the oscillator pin is already synchronous to mclk and slower than mclk/2
`timescale 1ns/1ps
`include "hib_map.vh"

module osc_predivider #(
    parameter XTAL_DIV    = `HIB_XTAL_DIV,
    parameter TRIM_PERIOD = `HIB_TRIM_PERIOD
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // oscillator pin
    input  wire        osc_in,
    // control
    input  wire        osc_enable,
    input  wire        osc_type_select,
    input  wire        count_enable,
    input  wire [15:0] trim,
    // one-second pulse
    output reg         second_tick_q
);

    reg         osc_prev_q;
    reg  [6:0]  xdiv_q;
    reg  [15:0] prediv_q;
    reg  [5:0]  sec_cnt_q;
    wire        osc_edge;
    wire        ref_tick;

    // rising edge of the pin, only while the source is enabled
    assign osc_edge = osc_enable & osc_in & ~osc_prev_q; // see [R08]
    // crystal path divides, oscillator path passes straight
    assign ref_tick = osc_type_select ? osc_edge :
                      (osc_edge && xdiv_q == XTAL_DIV - 1); // see [R07] see [R09]

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q    <= 1'b0;
            xdiv_q        <= 7'h00;
            prediv_q      <= `HIB_PREDIV_NOM;
            sec_cnt_q     <= 6'h00;
            second_tick_q <= 1'b0;
        end else begin
            osc_prev_q    <= osc_in;
            second_tick_q <= 1'b0;
            if (osc_edge && !osc_type_select)
                xdiv_q <= (xdiv_q == XTAL_DIV - 1) ? 7'h00 : xdiv_q + 7'h01; // see [R07]
            if (ref_tick && count_enable) begin
                if (prediv_q == 16'h0000) begin
                    second_tick_q <= 1'b1;
                    sec_cnt_q     <= (sec_cnt_q == TRIM_PERIOD - 1) ? 6'h00 : sec_cnt_q + 6'h01;
                    // trim replaces the divisor for one second in sixty-four
                    prediv_q <= (sec_cnt_q == TRIM_PERIOD - 2) ? trim : `HIB_PREDIV_NOM; // see [R18]
                end else begin
                    prediv_q <= prediv_q - 16'h0001;
                end
            end
        end
    end

endmodule

/* verification/osc_wake_source.sv */
// far side: free-running slow oscillator and pulled-up wake pin
// assumes mclk; oscillator runs at a third of mclk
`timescale 1ns/1ps
module osc_wake_source (
    // clock
    input  wire        mclk,
    // bench control
    input  wire        wake_assert,
    // pins
    output logic       osc_in = 1'b0,
    output wire        wake_n
);
    logic [1:0] ph_q = 2'h0;
    always @(posedge mclk) begin
        ph_q   <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
        osc_in <= (ph_q == 2'h0);
    end
    // pull-up when not asserted
    assign wake_n = wake_assert ? 1'b0 : 1'b1;
endmodule

/* verification/hibernation_power_control_chk.sv */
// port assertions for the hibernation controller
// assumes one mclk domain, bound to the design top
`timescale 1ns/1ps
module hibernation_power_control_chk (
    // clock and reset
    input wire        mclk,
    input wire        rst_n,
    // register port
    input wire [8:0]  addr,
    input wire [31:0] wr_data,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rd_data_q,
    // pins
    input wire        wake_n,
    input wire        low_batt,
    input wire        regulator_power_enable_n_q,
    input wire        event_pending_q
);
    wire off = regulator_power_enable_n_q;
    wire cw  = wr_en && addr == 9'h010;
    wire mw  = wr_en && addr == 9'h014;
    reg  pin_q;
    reg  tmr_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
            tmr_q <= 1'b0;
        end else if (cw) begin
            pin_q <= wr_data[4];
            tmr_q <= wr_data[3];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE: assert property (!rd_en |=> rd_data_q == 32'h0)
        else $error("read data not zero");
    AST_MASK_RB: assert property (mw ##1 rd_en && addr == 9'h014
        |=> rd_data_q == {28'h0, $past(wr_data[3:0], 2)}) else $error("mask readback");
    AST_ENTER: assert property (cw && wr_data[1] && |wr_data[4:3] && !off
        && !(wr_data[5] && wr_data[7] && low_batt) |-> ##[1:2] off) else $error("no entry");
    AST_ABORT: assert property (cw && wr_data[1] && wr_data[5] && wr_data[7]
        && low_batt && !off |=> !off [*3]) else $error("entry on low battery");
    AST_NOSRC: assert property (cw && wr_data[1] && wr_data[4:3] == 2'h0
        && !off |=> !off [*3]) else $error("entry without wake source");
    AST_PIN_WAKE: assert property (off && pin_q && !wake_n
        |-> ##[1:2] !off) else $error("pin wake missed");
    AST_HOLD: assert property (off && !tmr_q && (wake_n || !pin_q)
        |=> off) else $error("wake without enabled source");
    AST_EVT_OFF: assert property (mw && wr_data[3:0] == 4'h0 ##1 !mw
        |=> !event_pending_q) else $error("event with empty mask");
    cover property (off ##1 !off);
    cover property (cw && wr_data[7] && low_batt);
    cover property (rd_en ##1 rd_en);
endmodule
bind hibernation_power_control hibernation_power_control_chk i_chk (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_q(rd_data_q), .wake_n(wake_n), .low_batt(low_batt),
    .regulator_power_enable_n_q(regulator_power_enable_n_q),
    .event_pending_q(event_pending_q));

/* verification/hibernation_power_control_test.sv */
// register-port bench for the hibernation controller
// assumes the far side model drives oscillator and wake pin
`timescale 1ns/1ps
module hibernation_power_control_test;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [8:0]  addr = 9'h000;
    reg  [31:0] wr_data = 32'h0;
    reg         wr_en = 1'b0;
    reg         rd_en = 1'b0;
    reg         low_batt = 1'b0;
    reg         wake = 1'b0;
    wire [31:0] rd_data_q;
    wire        osc_in;
    wire        wake_n;
    wire        off;
    wire        evt;
    integer     fail_count = 0;
    integer     total_checks = 0;
    integer     i;
    always #10 mclk = ~mclk;
    osc_wake_source i_far (.mclk(mclk), .wake_assert(wake), .osc_in(osc_in),
        .wake_n(wake_n));
    hibernation_power_control i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
        .osc_in(osc_in), .wake_n(wake_n), .low_batt(low_batt),
        .regulator_power_enable_n_q(off), .event_pending_q(evt));
    task automatic chk_word(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input got, input exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input [8:0] a, input [31:0] d);
        @(posedge mclk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        rd_en   <= 1'b0;
    endtask
    task automatic rd(input [8:0] a, input [31:0] e);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        fork
            begin
                @(posedge mclk);
                #1 chk_word(rd_data_q, e);
            end
        join_none
    endtask
    task automatic idle(input integer n);
        @(posedge mclk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pins(input lb, input wk);
        @(posedge mclk);
        wr_en    <= 1'b0;
        rd_en    <= 1'b0;
        low_batt <= lb;
        wake     <= wk;
    endtask
    task print_verdict;
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #2500000;
        fail_count = fail_count + 1;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        idle(0);
        chk_bit(off, 1'b0);
        chk_bit(evt, 1'b0);
        rd(9'h010, 32'h0);
        rd(9'h024, 32'h7fff);
        rd(9'h004, 32'hffffffff);
        rd(9'h008, 32'hffffffff);
        rd(9'h000, 32'h0);
        rd(9'h018, 32'h0);
        rd(9'h028, 32'h0);
        rd(9'h00c, 32'h0);
        rd(9'h020, 32'h0);
        wr(9'h010, 32'h40);
        idle(4);
        rd(9'h010, 32'h40);
        wr(9'h024, 32'hffff1234);
        rd(9'h024, 32'h1234);
        wr(9'h024, 32'h7fff);
        wr(9'h100, 32'ha5a5c3c3);
        wr(9'h1fc, 32'h12345678);
        rd(9'h100, 32'ha5a5c3c3);
        rd(9'h1fc, 32'h12345678);
        wr(9'h014, 32'hff);
        rd(9'h014, 32'hf);
        wr(9'h014, 32'h0);
        wr(9'h010, 32'h44);
        rd(9'h010, 32'h44);
        wr(9'h010, 32'h46);
        idle(3);
        chk_bit(off, 1'b0);
        rd(9'h010, 32'h44);
        pins(1'b1, 1'b0);
        wr(9'h010, 32'hf6);
        idle(3);
        chk_bit(off, 1'b0);
        rd(9'h018, 32'h1);
        rd(9'h010, 32'hf4);
        wr(9'h014, 32'h1);
        idle(2);
        chk_bit(evt, 1'b1);
        rd(9'h01c, 32'h1);
        pins(1'b0, 1'b0);
        idle(3);
        wr(9'h020, 32'h1);
        rd(9'h018, 32'h0);
        idle(2);
        chk_bit(evt, 1'b0);
        wr(9'h010, 32'h56);
        idle(5);
        chk_bit(off, 1'b1);
        pins(1'b0, 1'b1);
        idle(4);
        chk_bit(off, 1'b0);
        pins(1'b0, 1'b0);
        rd(9'h018, 32'h8);
        rd(9'h010, 32'h54);
        wr(9'h020, 32'h8);
        wr(9'h00c, 32'h10);
        wr(9'h004, 32'h11);
        rd(9'h004, 32'h11);
        wr(9'h010, 32'h4d);
        idle(2);
        wr(9'h010, 32'h4f);
        idle(3);
        chk_bit(off, 1'b1);
        pins(1'b0, 1'b1);
        idle(3);
        chk_bit(off, 1'b1);
        pins(1'b0, 1'b0);
        for (i = 0; i < 110000 && off !== 1'b0; i = i + 1)
            @(posedge mclk);
        idle(1);
        chk_bit(off, 1'b0);
        rd(9'h000, 32'h11);
        rd(9'h018, 32'ha);
        idle(1);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        idle(0);
        chk_bit(off, 1'b0);
        rd(9'h010, 32'h0);
        rd(9'h000, 32'h0);
        rd(9'h100, 32'ha5a5c3c3);
        idle(1);
        print_verdict;
    end
endmodule
